// file: src/video_status_regs.svh
`ifndef VIDEO_STATUS_REGS_SVH
`define VIDEO_STATUS_REGS_SVH

// Sub-addresses of the read-only status and data bank
`define OFS_COPY_PROTECT_STATUS 8'h17
`define OFS_INPUT_VIDEO_STATUS 8'h18
`define OFS_CAPTION_DATA_LOW 8'h19
`define OFS_CAPTION_DATA_HIGH 8'h1A
`define OFS_WIDESCREEN_DATA_LOW 8'h1B
`define OFS_WIDESCREEN_DATA_HIGH 8'h1C
`define OFS_EXTENDED_CAPTION_LOW 8'h1D
`define OFS_EXTENDED_CAPTION_HIGH 8'h1E
`define OFS_COPY_GEN_ID_LOW 8'h1F
`define OFS_COPY_GEN_ID_HIGH 8'h20
`define OFS_PART_IDENTITY 8'h21

// Copy-protection status field positions
`define POS_PROTECT_PULSE_SEEN 0
`define POS_COLOR_STRIPE_SEEN 1
`define POS_COLOR_STRIPE_VARIANT 2

// Input video status field positions
`define POS_SUBCARRIER_CODE_LSB 0
`define POS_COLOR_SYSTEM_CODE_LSB 2
`define POS_LINE_COUNT_FLAG 4
`define POS_MONO_FLAG 5
`define POS_PEDESTAL_FLAG 6
`define POS_AUTO_DETECT_FLAG 7

// Identity field positions and widths
`define POS_PART_CODE_LSB 0
`define POS_REVISION_CODE_LSB 6
`define PART_CODE_WIDTH 6
`define REVISION_CODE_WIDTH 2

// Word widths of the captured services
`define CAPTION_WORD_WIDTH 16
`define EXTENDED_WORD_WIDTH 16
`define COPY_GEN_WORD_WIDTH 14
`define WIDESCREEN_WORD_WIDTH 14
`define SLOT_WORD_WIDTH 16
`define SERVICE_COUNT 4

// Reset and unmapped read values
`define READ_DATA_RESET 8'h00
`define UNMAPPED_READ_VALUE 8'h00
`define SLOT_WORD_RESET 16'h0000

`endif

// file: src/video_status_pkg.sv
package video_status_pkg;

    // Service slots, in the order of the request and presence bits
    typedef enum logic [1:0] {
        SVC_CAPTION = 2'h0,
        SVC_EXTENDED = 2'h1,
        SVC_COPY_GEN = 2'h2,
        SVC_WIDESCREEN = 2'h3
    } service_e;

    typedef logic [7:0] reg_byte_t;
    typedef logic [15:0] slot_word_t;

endpackage

// file: src/vbi_capture_slot.sv
`timescale 1ns/10ps
`default_nettype none
`include "video_status_regs.svh"

module vbi_capture_slot
    import video_status_pkg::*;
(
    input wire logic clk, // Core clock
    input wire logic rst_n, // Synchronised reset, active low
    input wire logic request, // Software asks for this service
    input wire logic strobe, // One-cycle pulse: decode finished
    input wire logic [15:0] word_in, // Freshly decoded word
    output logic [15:0] word_q, // Held word
    output logic present_q // Held word is valid decoded data
);

    slot_word_t word_d;
    logic present_d;

    // Word changes only on a completed decode, so multi-byte reads stay coherent
    always_comb begin
        word_d = word_q;
        present_d = present_q;
        if (strobe && request) begin
            word_d = word_in;
            present_d = 1'b1;
        end else if (!request) begin
            present_d = 1'b0; // Data kept, only the flag drops
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            word_q <= `SLOT_WORD_RESET;
            present_q <= 1'b0;
        end else begin
            word_q <= word_d;
            present_q <= present_d;
        end
    end

endmodule // vbi_capture_slot

`default_nettype wire

// file: src/video_status_vbi_readback_bank.sv
`timescale 1ns/10ps
`default_nettype none
`include "video_status_regs.svh"

// Behaviour
// R1: Copy-protect bit 0 reads 1 while AGC-type protection pulses are detected.
// R2: Copy-protect bit 1 reads 1 while a colour stripe pattern is detected.
// R3: Copy-protect bit 2 gives stripe variant, 0 type 2, 1 type 3; bits 7:3 reserved.
// R4: Input status bits 1:0 encode the detected subcarrier frequency.
// R5: Input status bits 3:2 encode NTSC, PAL or SECAM; 11 reserved.
// R6: Input status bit 4 is 0 for 525 lines, 1 for 625 lines.
// R7: Input status bit 5 reads 1 while monochrome processing is on.
// R8: Input status bit 6 reads 1 when input is processed with setup pedestal.
// R9: Input status bit 7 reads 1 when automatic standard detection is enabled.
// R10: Host programs subcarrier select to 11 for a SECAM input.
// R11: Caption word bits 7:0 at 0x19, bits 15:8 at 0x1A, natural order.
// R12: First widescreen register holds group one in 3:0, group two in 7:4.
// R13: Second widescreen register holds bits 8-10 in 2:0, 11-13 in 5:3.
// R14: Extended word bits 7:0 at 0x1D, bits 15:8 at 0x1E.
// R15: First copy-gen register holds id bits 1-6 reversed in 5:0; 7:6 reserved.
// R16: Second copy-gen register holds id bits 7-14, bit 7 at MSB.
// R17: Identity returns fixed 6-bit part code and 2-bit revision code.
// R18: Registers 0x17 to 0x21 are read-only, driven by internal logic only.
// R19: Per-service presence flags read 1 while their data registers hold decoded data; code clears a flag when its request drops, data kept.
// R20: Host sets per-service request bits to ask for decoding of a service.
// R21: Captured data holds its last value until the next decode of that service.
module video_status_vbi_readback_bank
    import video_status_pkg::*;
#(
    parameter logic [5:0] PART_CODE = 6'h15, // Arbitrary value
    parameter logic [1:0] REVISION_CODE = 2'h1 // Arbitrary value
) (
    input wire logic clk, // Core clock, 200 MHz
    input wire logic resetn, // Asynchronous reset, active low
    input wire logic protect_pulse_seen, // Detector: AGC-type pulses present
    input wire logic color_stripe_seen, // Detector: colour stripe present
    input wire logic color_stripe_variant, // Detector: 0 type 2, 1 type 3
    input wire logic [1:0] subcarrier_code, // Detected subcarrier code
    input wire logic [1:0] color_system_code, // Detected colour system code
    input wire logic line_count_flag, // 0 525 lines, 1 625 lines
    input wire logic mono_flag, // Monochrome processing on
    input wire logic pedestal_flag, // Processed with setup pedestal
    input wire logic auto_detect_on, // Standard auto-detection enabled
    input wire logic [3:0] service_req, // Request bits from request register
    input wire logic [3:0] capture_strobe, // Slicer done pulses, per service
    input wire logic [15:0] caption_word, // Decoded caption word
    input wire logic [15:0] extended_word, // Decoded extended data word
    input wire logic [13:0] copy_gen_word, // Decoded id, index i is id bit i+1
    input wire logic [13:0] widescreen_word, // Decoded widescreen bits 0 to 13
    input wire logic rd_req, // One-cycle read request from serial engine
    input wire logic [7:0] rd_addr, // Sub-address of the read
    output logic [7:0] rd_data, // Read data, held until next read
    output logic rd_ack, // One-cycle pulse: rd_data valid
    output logic rd_hit, // Last read hit this bank
    output logic [3:0] present_flags // Per-service data present
);

    logic rst_sync1_q;
    logic rst_sync2_q;
    logic rst_n;

    // Release of reset is retimed to clk; assertion stays asynchronous
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            rst_sync1_q <= 1'b0;
            rst_sync2_q <= 1'b0;
        end else begin
            rst_sync1_q <= 1'b1;
            rst_sync2_q <= rst_sync1_q;
        end
    end

    assign rst_n = rst_sync2_q;

    // Widen the copy-gen and widescreen words to the common slot width
    logic [15:0] slot_in [`SERVICE_COUNT];
    logic [15:0] slot_word [`SERVICE_COUNT];
    logic [3:0] slot_present;

    assign slot_in[SVC_CAPTION] = caption_word;
    assign slot_in[SVC_EXTENDED] = extended_word;
    assign slot_in[SVC_COPY_GEN] = {2'h0, copy_gen_word};
    assign slot_in[SVC_WIDESCREEN] = {2'h0, widescreen_word};

    // One capture slot per vertical-blanking service
    genvar svc;
    generate
        for (svc = 0; svc < `SERVICE_COUNT; svc++) begin : g_slot
            vbi_capture_slot u_slot (
                .clk(clk),
                .rst_n(rst_n),
                .request(service_req[svc]), // [R20]
                .strobe(capture_strobe[svc]), // [R21]
                .word_in(slot_in[svc]),
                .word_q(slot_word[svc]),
                .present_q(slot_present[svc])
            );
        end
    endgenerate

    assign present_flags = slot_present; // [R19]

    // Assemble each register image from live status, held words or the identity parameters
    reg_byte_t copy_protect_img;
    reg_byte_t input_video_img;
    reg_byte_t caption_low_img;
    reg_byte_t caption_high_img;
    reg_byte_t widescreen_low_img;
    reg_byte_t widescreen_high_img;
    reg_byte_t extended_low_img;
    reg_byte_t extended_high_img;
    reg_byte_t copy_gen_low_img;
    reg_byte_t copy_gen_high_img;
    reg_byte_t identity_img;

    always_comb begin
        copy_protect_img = 8'h00; // Reserved bits read zero [R3]
        copy_protect_img[`POS_PROTECT_PULSE_SEEN] = protect_pulse_seen; // [R1]
        copy_protect_img[`POS_COLOR_STRIPE_SEEN] = color_stripe_seen; // [R2]
        copy_protect_img[`POS_COLOR_STRIPE_VARIANT] = color_stripe_variant; // [R3]
    end

    // Subcarrier code is reported as detected; the SECAM select fix-up is host work
    always_comb begin
        input_video_img = 8'h00;
        input_video_img[`POS_SUBCARRIER_CODE_LSB +: 2] = subcarrier_code; // [R4]
        input_video_img[`POS_COLOR_SYSTEM_CODE_LSB +: 2] = color_system_code; // [R5]
        input_video_img[`POS_LINE_COUNT_FLAG] = line_count_flag; // [R6]
        input_video_img[`POS_MONO_FLAG] = mono_flag; // [R7]
        input_video_img[`POS_PEDESTAL_FLAG] = pedestal_flag; // [R8]
        input_video_img[`POS_AUTO_DETECT_FLAG] = auto_detect_on; // [R9]
    end

    // Caption and extended words sit in natural bit order
    always_comb begin
        caption_low_img = slot_word[SVC_CAPTION][7:0]; // [R11]
        caption_high_img = slot_word[SVC_CAPTION][15:8]; // [R11]
        extended_low_img = slot_word[SVC_EXTENDED][7:0]; // [R14]
        extended_high_img = slot_word[SVC_EXTENDED][15:8]; // [R14]
    end

    // Widescreen groups map straight through; top two bits reserved
    always_comb begin
        widescreen_low_img = slot_word[SVC_WIDESCREEN][7:0]; // [R12]
        widescreen_high_img = {2'h0, slot_word[SVC_WIDESCREEN][13:8]}; // [R13]
    end

    // Copy-gen id bits are stored reversed: earliest bit in the highest position
    always_comb begin
        copy_gen_low_img = 8'h00;
        copy_gen_high_img = 8'h00;
        for (int k = 0; k < 6; k++) begin
            copy_gen_low_img[5 - k] = slot_word[SVC_COPY_GEN][k]; // [R15]
        end
        for (int k = 0; k < 8; k++) begin
            copy_gen_high_img[7 - k] = slot_word[SVC_COPY_GEN][6 + k]; // [R16]
        end
    end

    // Identity is a constant; revision changes only through the REVISION_CODE parameter
    always_comb begin
        identity_img = 8'h00;
        identity_img[`POS_PART_CODE_LSB +: `PART_CODE_WIDTH] = PART_CODE; // [R17]
        identity_img[`POS_REVISION_CODE_LSB +: `REVISION_CODE_WIDTH] = REVISION_CODE; // [R17]
    end

    // Read decode; there is no write path into this bank at all
    reg_byte_t rd_data_d;
    reg_byte_t rd_data_q;
    logic rd_ack_d;
    logic rd_ack_q;
    logic rd_hit_d;
    logic rd_hit_q;
    reg_byte_t sel_data;
    logic sel_hit;

    always_comb begin
        sel_hit = 1'b1;
        case (rd_addr) // [R18]
            `OFS_COPY_PROTECT_STATUS: sel_data = copy_protect_img;
            `OFS_INPUT_VIDEO_STATUS: sel_data = input_video_img;
            `OFS_CAPTION_DATA_LOW: sel_data = caption_low_img;
            `OFS_CAPTION_DATA_HIGH: sel_data = caption_high_img;
            `OFS_WIDESCREEN_DATA_LOW: sel_data = widescreen_low_img;
            `OFS_WIDESCREEN_DATA_HIGH: sel_data = widescreen_high_img;
            `OFS_EXTENDED_CAPTION_LOW: sel_data = extended_low_img;
            `OFS_EXTENDED_CAPTION_HIGH: sel_data = extended_high_img;
            `OFS_COPY_GEN_ID_LOW: sel_data = copy_gen_low_img;
            `OFS_COPY_GEN_ID_HIGH: sel_data = copy_gen_high_img;
            `OFS_PART_IDENTITY: sel_data = identity_img;
            default: begin
                sel_data = `UNMAPPED_READ_VALUE;
                sel_hit = 1'b0;
            end
        endcase
    end

    // Data is sampled once per request and then held, so it cannot change mid-shift
    always_comb begin
        rd_data_d = rd_data_q;
        rd_hit_d = rd_hit_q;
        rd_ack_d = 1'b0;
        if (rd_req) begin
            rd_data_d = sel_data;
            rd_hit_d = sel_hit;
            rd_ack_d = 1'b1;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rd_data_q <= `READ_DATA_RESET;
            rd_ack_q <= 1'b0;
            rd_hit_q <= 1'b0;
        end else begin
            rd_data_q <= rd_data_d;
            rd_ack_q <= rd_ack_d;
            rd_hit_q <= rd_hit_d;
        end
    end

    assign rd_data = rd_data_q;
    assign rd_ack = rd_ack_q;
    assign rd_hit = rd_hit_q;

endmodule // video_status_vbi_readback_bank

`default_nettype wire

// file: bench/video_status_bank_chk_assertions.sv
`timescale 1ns/10ps
`default_nettype none
module video_status_bank_chk #(
    parameter logic [5:0] PART_CODE = 6'h15, // Arbitrary value
    parameter logic [1:0] REVISION_CODE = 2'h1 // Arbitrary value
) (
    input wire logic clk, // Core clock
    input wire logic resetn, // Reset, active low
    input wire logic protect_pulse_seen, // Detector flag
    input wire logic color_stripe_seen, // Detector flag
    input wire logic color_stripe_variant, // Detector flag
    input wire logic [1:0] subcarrier_code, // Status field
    input wire logic [1:0] color_system_code, // Status field
    input wire logic line_count_flag, // Status flag
    input wire logic mono_flag, // Status flag
    input wire logic pedestal_flag, // Status flag
    input wire logic auto_detect_on, // Status flag
    input wire logic [3:0] service_req, // Requests
    input wire logic [3:0] capture_strobe, // Decode done
    input wire logic [15:0] caption_word, // Caption word
    input wire logic rd_req, // Read pulse
    input wire logic [7:0] rd_addr, // Read address
    input wire logic [7:0] rd_data, // Read data
    input wire logic rd_ack, // Read answer
    input wire logic rd_hit, // Address in bank
    input wire logic [3:0] present_flags // Data present
);
    // One clock domain, so clocking and reset are given once
    default clocking @(posedge clk); endclocking
    default disable iff (!resetn);

    AST_READ_LATENCY: assert property (rd_req |=> rd_ack)
        else $error("read not answered one cycle later");
    AST_ACK_PULSE: assert property (!rd_req |=> !rd_ack)
        else $error("answer without a read");
    AST_PROTECT: assert property (rd_req && rd_addr == 8'h17 |=> rd_data == {5'h00,
        $past(color_stripe_variant), $past(color_stripe_seen), $past(protect_pulse_seen)})
        else $error("copy-protect status byte wrong");
    AST_VIDEO: assert property (rd_req && rd_addr == 8'h18 |=> rd_data == $past({
        auto_detect_on, pedestal_flag, mono_flag, line_count_flag, color_system_code,
        subcarrier_code})) else $error("input video status byte wrong");
    AST_IDENT: assert property (rd_req && rd_addr == 8'h21 |=>
        rd_data == {REVISION_CODE, PART_CODE} && rd_hit) else $error("identity byte wrong");
    AST_UNMAPPED: assert property (rd_req && (rd_addr < 8'h17 || rd_addr > 8'h21) |=>
        rd_data == 8'h00 && !rd_hit) else $error("unmapped read not refused");
    AST_PRESENT_SET: assert property (|(service_req & capture_strobe) |=>
        (present_flags & $past(service_req & capture_strobe)) == $past(service_req & capture_strobe))
        else $error("presence not set by accepted capture");
    AST_PRESENT_CLR: assert property (service_req != 4'hF |=>
        (present_flags & ~$past(service_req)) == 4'h0) else $error("presence without request");
    AST_CAPTION_HOLD: assert property (capture_strobe[0] && service_req[0] ##1
        rd_req && rd_addr == 8'h1A |=> rd_data == $past(caption_word[15:8], 2))
        else $error("caption high byte not captured word");
endmodule // video_status_bank_chk

bind video_status_vbi_readback_bank video_status_bank_chk #(
    .PART_CODE(PART_CODE),
    .REVISION_CODE(REVISION_CODE)
) u_chk (.*);
`default_nettype wire

// file: bench/host_reader_model.sv
`timescale 1ns/10ps
`default_nettype none
module host_reader_model (
    input wire logic clk, // Core clock
    input wire logic [7:0] rd_data, // Read data from the bank
    input wire logic rd_ack, // Read answer pulse
    output logic rd_req, // One-cycle read pulse
    output logic [7:0] rd_addr, // Sub-address
    output logic [3:0] service_req // Per-service decode requests
);
    // Idle host: no read, no service asked for
    initial begin
        rd_req = 1'b0;
        rd_addr = 8'h00;
        service_req = 4'h0;
    end
    // Host asks the slicer for a service by setting its bit
    task automatic set_req(input logic [3:0] req);
        service_req <= req;
    endtask
    // Call just after an edge; address stays put until the answer edge
    task automatic read(input logic [7:0] a, output logic [7:0] d, output logic ok);
        ok = 1'b0;
        rd_req <= 1'b1;
        rd_addr <= a;
        @(posedge clk);
        rd_req <= 1'b0;
        for (int i = 0; i < 4 && !ok; i++) begin
            @(posedge clk);
            ok = (rd_ack === 1'b1);
        end
        d = rd_data;
        rd_addr <= ~a; // Released address must not look still valid
    endtask
endmodule // host_reader_model
`default_nettype wire

// file: bench/video_status_vbi_readback_bank_tb.sv
`timescale 1ns/10ps
`default_nettype none
module video_status_vbi_readback_bank_tb;
    logic clk, resetn, rd_req, rd_ack, rd_hit;
    logic [2:0] prot;
    logic [7:0] vid, rd_addr, rd_data;
    logic [3:0] strobe, service_req, present_flags;
    logic [15:0] cap, ext, exp_cg;
    logic [13:0] cg, wss;
    logic [7:0] vid_tab [5] = '{8'hA5, 8'h5A, 8'hF0, 8'h0F, 8'h1B};
    int errors = 0;
    int tests_run = 0;

    video_status_vbi_readback_bank dut (.clk(clk), .resetn(resetn),
        .protect_pulse_seen(prot[0]), .color_stripe_seen(prot[1]),
        .color_stripe_variant(prot[2]), .subcarrier_code(vid[1:0]),
        .color_system_code(vid[3:2]), .line_count_flag(vid[4]), .mono_flag(vid[5]),
        .pedestal_flag(vid[6]), .auto_detect_on(vid[7]), .service_req(service_req),
        .capture_strobe(strobe), .caption_word(cap), .extended_word(ext),
        .copy_gen_word(cg), .widescreen_word(wss), .rd_req(rd_req), .rd_addr(rd_addr),
        .rd_data(rd_data), .rd_ack(rd_ack), .rd_hit(rd_hit), .present_flags(present_flags));
    host_reader_model host (.clk(clk), .rd_data(rd_data), .rd_ack(rd_ack), .rd_req(rd_req),
        .rd_addr(rd_addr), .service_req(service_req));

    // 200 MHz core clock
    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        tests_run++;
        if (got !== exp) begin
            errors++;
            $display("FAIL %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic test_done();
        $display("errors %0d tests_run %0d", errors, tests_run);
        if (errors == 0 && tests_run > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask
    // A missing answer ends the run rather than hanging
    task automatic rd(input logic [7:0] a, input logic [7:0] exp);
        logic [7:0] d;
        logic ok;
        host.read(a, d, ok);
        if (ok !== 1'b1) begin
            errors++;
            $display("FAIL %0t no answer to read of %h", $time, a);
            test_done();
        end else begin
            chk(d, exp);
        end
    endtask
    // Copy-gen id: low byte bit 5-k is id index k, high byte bit 7-k is index 6+k
    function automatic logic [15:0] cg_exp(input logic [13:0] w);
        cg_exp = 16'h0000;
        for (int k = 0; k < 6; k++) cg_exp[5 - k] = w[k];
        for (int k = 0; k < 8; k++) cg_exp[15 - k] = w[6 + k];
    endfunction

    initial begin
        resetn = 1'b0;
        prot = 3'h0;
        vid = 8'h00;
        strobe = 4'h0;
        {cap, ext, cg, wss} = '0;
        repeat (20) @(posedge clk);
        resetn <= 1'b1;
        repeat (3) @(posedge clk);
        rd(8'h21, {2'h1, 6'h15});
        for (int i = 0; i < 8; i++) begin
            prot <= i[2:0];
            @(posedge clk);
            rd(8'h17, {5'h00, i[2:0]});
        end
        // Last entry pairs SECAM with subcarrier 11, as host software sets it
        foreach (vid_tab[i]) begin
            vid <= vid_tab[i];
            @(posedge clk);
            rd(8'h18, vid_tab[i]);
        end
        host.set_req(4'hF);
        cap <= 16'hBEEF;
        ext <= 16'h1234;
        cg <= 14'h2D5B;
        wss <= 14'h3A6C;
        strobe <= 4'hF;
        @(posedge clk);
        strobe <= 4'h0;
        rd(8'h1A, 8'hBE);
        {cap, ext, cg, wss} <= '0; // Words move on without a strobe
        chk({4'h0, present_flags}, 8'h0F);
        exp_cg = cg_exp(14'h2D5B);
        rd(8'h19, 8'hEF);
        rd(8'h1B, 8'h6C);
        rd(8'h1C, 8'h3A);
        rd(8'h1D, 8'h34);
        rd(8'h1E, 8'h12);
        rd(8'h1F, exp_cg[7:0]);
        rd(8'h20, exp_cg[15:8]);
        // Strobe without request must be ignored
        host.set_req(4'hE);
        cap <= 16'h5AA5;
        strobe <= 4'h1;
        @(posedge clk);
        strobe <= 4'h0;
        @(posedge clk);
        chk({4'h0, present_flags}, 8'h0E);
        rd(8'h19, 8'hEF);
        rd(8'h16, 8'h00);
        chk({7'h00, rd_hit}, 8'h00);
        rd(8'h22, 8'h00);
        test_done();
    end
endmodule // video_status_vbi_readback_bank_tb
`default_nettype wire
